// file: src/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_state_s;

  sync_state_s s_q;
  sync_state_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.q    = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule

`default_nettype wire

// file: src/tape_buf_pkg.sv
package tape_buf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned REQ_DELAY_NS  = 2000;
  localparam int unsigned NS_PER_US     = 1000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_FLAGS  = 4'h8;

  // Event and flag bit positions, shared by status, mask and flags
  localparam int EV_WREQ  = 0;
  localparam int EV_UNDER = 1;
  localparam int EV_RREQ  = 2;
  localparam int EV_LOST  = 3;
  localparam int EV_SYNC  = 4;
  localparam int EV_W     = 5;
  localparam int FL_HOLD  = 5;
  localparam int FL_BYTE  = 6;

  localparam logic [EV_W-1:0] MASK_RST   = 5'h00;
  localparam logic [2:0]      TX_CNT_RST = 3'h7;
  localparam logic [2:0]      TX_CNT_LD  = 3'h6;
  localparam logic [2:0]      RX_CNT_END = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_SEARCH = 2'b01,
    RX_BYTE   = 2'b10
  } rx_mode_e;

  typedef struct packed {
    logic        tclk;
    logic        rclk;
    logic        rdin;
    logic        rgate;
    logic        whs;
    logic        fbs;
    logic        sbs;
    logic        rrc;
    logic        roe;
    logic [7:0]  wdata;
  } pins_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_s;

  typedef struct packed {
    pins_s           pin_prev;
    logic [2:0]      tx_cnt;
    logic [7:0]      tx_cur;
    logic            serial;
    logic [7:0]      hold;
    logic            hold_valid;
    logic [7:0]      fill;
    logic            write_request;
    logic            underrun;
    logic [15:0]     wdly_cnt;
    logic            wdly_run;
    rx_mode_e        rx_mode;
    logic [7:0]      rx_shift;
    logic [2:0]      rx_cnt;
    logic            rx_done;
    logic [7:0]      rx_byte;
    logic [15:0]     rdly_cnt;
    logic            rdly_run;
    logic            lost_pend;
    logic            rx_arm;
    logic [7:0]      sync_reg;
    logic [7:0]      read_data;
    logic            read_request;
    logic            lost;
    logic            sync_flag;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic            ack;
    logic [7:0]      rdata;
  } state_s;

endpackage

// file: src/tape_byte_buffer.sv
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module tape_byte_buffer #(
  parameter int unsigned REQ_NS = tape_buf_pkg::REQ_DELAY_NS
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   transmit_clock,
  input  wire logic                   receive_clock,
  input  wire logic                   serial_read_in,
  input  wire logic                   read_gate,
  input  wire logic                   write_holding_strobe,
  input  wire logic                   fill_byte_strobe,
  input  wire logic                   sync_byte_strobe,
  input  wire logic                   read_request_clear,
  input  wire logic                   read_output_enable,
  input  wire logic [7:0]             write_data_in,
  output logic                        serial_write_out,
  output logic                        write_request,
  output logic                        write_underrun_flag,
  output logic                        read_request,
  output logic                        read_lost_flag,
  output logic                        sync_match_flag,
  output logic [7:0]                  parallel_read_bus_o,
  output logic                        parallel_read_bus_oe,
  input  wire tape_buf_pkg::avs_req_s avs_req,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        irq
);
  import tape_buf_pkg::*;

  // Delay counts round down; never below one cycle
  localparam int unsigned REQ_RAW = (REQ_NS * CLK_MHZ) / NS_PER_US;
  localparam logic [15:0] REQ_CYC = 16'((REQ_RAW < 1) ? 1 : REQ_RAW);

  localparam state_s ST_RST = '{
    rx_mode: RX_SEARCH,
    tx_cnt:  TX_CNT_RST,
    mask:    MASK_RST,
    default: '0
  };
  state_s s_q;
  state_s s_d;
  pins_s  pin;

  logic            tx_edge;
  logic            rx_fall;
  logic            whs_rise;
  logic            fbs_rise;
  logic            sbs_rise;
  logic            rrc_rise;
  logic            tx_load;
  logic            wdly_end;
  logic            rdly_end;
  logic [7:0]      rx_shift_next;
  logic            bus_req;
  logic            bus_take;
  logic [EV_W-1:0] ev;
  logic [6:0]      flags;

  // ----------------------------------------------------------------
  // Input synchronisers and edge finding
  // ----------------------------------------------------------------
  pin_sync #(
    .W ($bits(pins_s))
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({transmit_clock, receive_clock, serial_read_in, read_gate,
            write_holding_strobe, fill_byte_strobe, sync_byte_strobe,
            read_request_clear, read_output_enable, write_data_in}),
    .q    (pin)
  );

  assign tx_edge       = pin.tclk & ~s_q.pin_prev.tclk;
  assign rx_fall       = ~pin.rclk & s_q.pin_prev.rclk;
  assign whs_rise      = pin.whs & ~s_q.pin_prev.whs;
  assign fbs_rise      = pin.fbs & ~s_q.pin_prev.fbs;
  assign sbs_rise      = pin.sbs & ~s_q.pin_prev.sbs;
  assign rrc_rise      = pin.rrc & ~s_q.pin_prev.rrc;
  assign tx_load       = tx_edge & (s_q.tx_cnt == TX_CNT_LD);
  assign wdly_end      = s_q.wdly_run & (s_q.wdly_cnt == 16'h0001);
  assign rdly_end      = s_q.rdly_run & (s_q.rdly_cnt == 16'h0001) & ~(rx_fall & s_q.rx_done);
  assign rx_shift_next = {pin.rdin, s_q.rx_shift[7:1]};
  assign bus_req       = avs_req.read | avs_req.write;
  assign bus_take      = bus_req & s_q.ack;

  assign flags = {s_q.rx_mode == RX_BYTE, s_q.hold_valid, s_q.sync_flag,
                  s_q.lost, s_q.read_request, s_q.underrun, s_q.write_request};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    ev           = '0;
    s_d.pin_prev = pin;

    // Transmit side: one bit per rising transmit clock edge, LSB first
    if (tx_edge) begin
      s_d.tx_cnt = s_q.tx_cnt + 3'd1;
      if (tx_load) begin
        s_d.serial     = s_q.tx_cur[7];
        s_d.tx_cur     = s_q.hold_valid ? s_q.hold : s_q.fill;
        s_d.hold_valid = 1'b0;
        s_d.wdly_cnt   = REQ_CYC;
        s_d.wdly_run   = 1'b1;
        if (!s_q.hold_valid) begin
          s_d.underrun    = 1'b1;
          ev[EV_UNDER]    = 1'b1;
        end
      end else begin
        s_d.serial = s_q.tx_cur[s_q.tx_cnt + 3'd1];
      end
    end

    // Write request follows the reload after the fixed delay
    if (s_q.wdly_run && !tx_load) begin
      s_d.wdly_cnt = s_q.wdly_cnt - 16'd1;
      if (wdly_end) begin
        s_d.wdly_run = 1'b0;
        if (!s_q.hold_valid && !whs_rise) begin
          s_d.write_request = 1'b1;
          ev[EV_WREQ]       = 1'b1;
        end
      end
    end

    // A strobe that beats the reload edge supplies the next byte
    if (whs_rise) begin
      s_d.hold          = pin.wdata;
      s_d.hold_valid    = 1'b1;
      s_d.write_request = 1'b0;
      if (!(tx_load && !s_q.hold_valid)) begin
        s_d.underrun = 1'b0;
      end
    end
    if (fbs_rise) begin
      s_d.fill = pin.wdata;
    end
    if (sbs_rise) begin
      s_d.sync_reg = pin.wdata;
    end

    // Clear comes first so a same-cycle set wins
    if (rrc_rise) begin
      s_d.read_request = 1'b0;
    end

    // Receive side: sample on falling receive clock edges
    if (rx_fall && !pin.rgate) begin
      s_d.rx_shift = rx_shift_next;
      if (s_q.rx_done) begin
        s_d.rx_done   = 1'b0;
        s_d.lost_pend = s_q.read_request;
        s_d.rdly_cnt  = REQ_CYC;
        s_d.rdly_run  = 1'b1;
      end
      if (s_q.rx_arm) begin
        s_d.rx_arm       = 1'b0;
        s_d.read_request = 1'b1;
        ev[EV_RREQ]      = 1'b1;
      end
      unique case (s_q.rx_mode)
        RX_SEARCH: begin
          if (rx_shift_next == s_q.sync_reg) begin
            s_d.rx_mode = RX_BYTE;
            s_d.rx_cnt  = 3'd0;
            s_d.rx_done = 1'b1;
            s_d.rx_byte = rx_shift_next;
          end
        end
        RX_BYTE: begin
          s_d.rx_cnt = s_q.rx_cnt + 3'd1;
          if (s_q.rx_cnt == RX_CNT_END) begin
            s_d.rx_done = 1'b1;
            s_d.rx_byte = rx_shift_next;
          end
        end
        default: begin
          s_d.rx_mode = RX_SEARCH;
        end
      endcase
    end

    // Status outputs update when the receive delay runs out
    if (s_q.rdly_run && !(rx_fall && s_q.rx_done)) begin
      s_d.rdly_cnt = s_q.rdly_cnt - 16'd1;
      if (rdly_end) begin
        s_d.rdly_run  = 1'b0;
        s_d.read_data = s_q.rx_byte;
        s_d.sync_flag = (s_q.rx_byte == s_q.sync_reg);
        s_d.rx_arm    = 1'b1;
        if (s_q.lost_pend) begin
          s_d.lost     = 1'b1;
          ev[EV_LOST]  = 1'b1;
        end
        if (s_q.rx_byte == s_q.sync_reg) begin
          ev[EV_SYNC] = 1'b1;
        end
      end
    end

    // Gate high holds the reader idle; its fall starts the search
    if (pin.rgate) begin
      s_d.read_request = 1'b0;
      s_d.sync_flag    = 1'b0;
      s_d.lost         = 1'b0;
      s_d.rx_mode      = RX_SEARCH;
      s_d.rx_done      = 1'b0;
      s_d.rdly_run     = 1'b0;
      s_d.rx_arm       = 1'b0;
      ev[EV_RREQ]      = 1'b0;
      ev[EV_LOST]      = 1'b0;
      ev[EV_SYNC]      = 1'b0;
    end

    // Bus slave: one wait cycle, then the answer
    s_d.ack = bus_req & ~s_q.ack;
    if (bus_req && !s_q.ack) begin
      unique case (avs_req.address)
        ADDR_STATUS: s_d.rdata = {3'd0, s_q.status};
        ADDR_MASK:   s_d.rdata = {3'd0, s_q.mask};
        ADDR_FLAGS:  s_d.rdata = {1'b0, flags};
        default:     s_d.rdata = 8'h00;
      endcase
    end

    // Read clears only what was reported, so new events survive
    s_d.status = s_q.status | ev;
    if (bus_take && avs_req.read && avs_req.address == ADDR_STATUS) begin
      s_d.status = (s_q.status & ~s_q.rdata[EV_W-1:0]) | ev;
    end
    if (bus_take && avs_req.write && avs_req.address == ADDR_MASK
        && avs_req.byteenable[0]) begin
      s_d.mask = avs_req.writedata[EV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_write_out     = s_q.serial;
  assign write_request        = s_q.write_request;
  assign write_underrun_flag  = s_q.underrun;
  assign read_request         = s_q.read_request;
  assign read_lost_flag       = s_q.lost;
  assign sync_match_flag      = s_q.sync_flag;
  assign parallel_read_bus_o  = s_q.read_data;
  assign parallel_read_bus_oe = pin.roe;
  assign avs_readdata         = {24'h00_0000, s_q.rdata};
  assign avs_waitrequest      = bus_req & ~s_q.ack;
  assign irq                  = |(s_q.status & s_q.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_reload;
    (tx_load && s_q.hold_valid && !whs_rise)
      |=> (s_q.tx_cur == $past(s_q.hold)) && !s_q.hold_valid;
  endproperty
  a_reload: assert property (p_reload) else $error("reload byte wrong");

  property p_wreq_rise;
    $rose(write_request) |-> $past(wdly_end);
  endproperty
  a_wreq_rise: assert property (p_wreq_rise) else $error("write request early");

  property p_wreq_due;
    (wdly_end && !tx_load && !s_q.hold_valid && !whs_rise) |=> write_request;
  endproperty
  a_wreq_due: assert property (p_wreq_due) else $error("write request missing");

  property p_data_update;
    (rdly_end && !pin.rgate) |=> parallel_read_bus_o == $past(s_q.rx_byte);
  endproperty
  a_data_update: assert property (p_data_update) else $error("read data not updated");

  property p_rreq_rise;
    $rose(read_request) |-> $past(rx_fall) && $past(s_q.rx_arm);
  endproperty
  a_rreq_rise: assert property (p_rreq_rise) else $error("read request timing");

  property p_bus_off;
    (!read_output_enable) [*3] |-> !parallel_read_bus_oe;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("read bus driven while off");

  property p_sync_hit;
    (rx_fall && !pin.rgate && s_q.rx_mode == RX_SEARCH && rx_shift_next == s_q.sync_reg)
      |=> s_q.rx_mode == RX_BYTE && s_q.rx_done;
  endproperty
  a_sync_hit: assert property (p_sync_hit) else $error("sync byte missed");

  property p_underrun;
    (tx_load && !s_q.hold_valid) |=> write_underrun_flag && s_q.tx_cur == $past(s_q.fill);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_lost;
    (rdly_end && s_q.lost_pend && !pin.rgate) |=> read_lost_flag;
  endproperty
  a_lost: assert property (p_lost) else $error("lost flag missing");

  property p_gate_clear;
    pin.rgate |=> !read_request && !sync_match_flag && !read_lost_flag;
  endproperty
  a_gate_clear: assert property (p_gate_clear) else $error("gate did not clear");

  c_underrun: cover property ($rose(write_underrun_flag));
  c_sync:     cover property ($rose(sync_match_flag) ##[1:1000] $rose(read_request));
  c_lost:     cover property ($rose(read_lost_flag));
  c_irq:      cover property ($rose(irq));

endmodule

`default_nettype wire

// file: testbench/tape_byte_buffer_test.sv
`timescale 1ns/1ns
`default_nettype none

module tape_byte_buffer_test;
  import tape_buf_pkg::*;
  // --------
  // Pins
  // --------
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  pv = 5'h00;
  logic        read_output_enable = 1'b0;
  logic [7:0]  write_data_in = 8'h00;
  avs_req_s    avs_req = '0;
  logic        tx_run = 1'b0;
  logic        rx_run = 1'b0;
  logic        transmit_clock, receive_clock, serial_read_in, serial_write_out;
  logic        write_request, write_underrun_flag, read_request, read_lost_flag;
  logic        sync_match_flag, parallel_read_bus_oe, avs_waitrequest, irq;
  logic [7:0]  parallel_read_bus_o, tx_cap;
  logic [31:0] avs_readdata, got;
  int          tx_falls, rx_bits;
  int          n_errors = 0;
  int          tests_run = 0;

  always #2 clk = ~clk;

  // Short request delay keeps both link byte times realistic
  tape_byte_buffer #(.REQ_NS(40)) i_dut (
    .clk, .srst, .transmit_clock, .receive_clock, .serial_read_in,
    .read_gate(pv[4]), .write_holding_strobe(pv[0]), .fill_byte_strobe(pv[1]),
    .sync_byte_strobe(pv[2]), .read_request_clear(pv[3]), .read_output_enable,
    .write_data_in, .serial_write_out, .write_request, .write_underrun_flag,
    .read_request, .read_lost_flag, .sync_match_flag, .parallel_read_bus_o,
    .parallel_read_bus_oe, .avs_req, .avs_readdata, .avs_waitrequest, .irq
  );

  tape_drive_model i_drive (
    .clk, .srst, .tx_run, .rx_run, .serial_write_out,
    .rx_pattern(40'h00_C35A_9600), .transmit_clock, .receive_clock,
    .serial_read_in, .tx_cap, .tx_falls, .rx_bits
  );

  // --------
  // Tasks
  // --------
  task automatic give_verdict;
    $display("errors %0d of %0d comparisons", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wdat);
    int n;
    n = 0;
    @(posedge clk);
    avs_req <= {~wr, wr, a, wdat, 4'hF};
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_errors++;
      give_verdict();
    end
    got = avs_readdata;
    @(posedge clk);
    avs_req <= '0;
  endtask

  task automatic pulse(input int k, input logic [7:0] d, input int len);
    @(posedge clk);
    write_data_in <= d;
    @(posedge clk);
    pv[k] <= 1'b1;
    repeat (len) @(posedge clk);
    pv[k] <= 1'b0;
    repeat (4) @(negedge clk);
  endtask

  function automatic logic [31:0] pick(input int k);
    case (k)
      0: return tx_falls;
      1: return {31'h0000_0000, read_request};
      default: return {31'h0000_0000, read_lost_flag};
    endcase
  endfunction

  task automatic wait_for(input int k, input logic [31:0] v);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (pick(k) === v) break;
    end
    if (n >= 4000) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic read_bus(input logic [7:0] e);
    @(posedge clk);
    read_output_enable <= 1'b1;
    repeat (3) @(negedge clk);
    chk({parallel_read_bus_oe, parallel_read_bus_o}, {1'b1, e});
    @(posedge clk);
    read_output_enable <= 1'b0;
    repeat (3) @(negedge clk);
    chk(parallel_read_bus_oe, 1'b0);
  endtask

  // --------
  // Sequence
  // --------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    pulse(4, 8'h00, 20);
    chk({read_request, read_lost_flag, sync_match_flag}, 3'b000);
    bus(1'b0, ADDR_MASK, 32'h0000_0000);
    chk(got, 32'h0000_0000);
    bus(1'b1, ADDR_MASK, 32'h0000_0002);
    bus(1'b0, ADDR_MASK, 32'h0000_0000);
    chk(got, 32'h0000_0002);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(got, 32'h0000_0000);
    pulse(1, 8'hA5, 5);
    pulse(0, 8'h3C, 5);
    tx_run <= 1'b1;
    wait_for(0, 8);
    chk(write_request, 1'b0);
    repeat (14) @(negedge clk);
    chk(write_request, 1'b1);
    wait_for(0, 16);
    chk(tx_cap, 8'h3C);
    wait_for(0, 24);
    chk({write_underrun_flag, irq, tx_cap}, {2'b11, 8'hA5});
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(got, 32'h0000_0003);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    // Strobe well ahead of the next reload
    pulse(0, 8'h81, 5);
    chk({write_request, write_underrun_flag}, 2'b00);
    wait_for(0, 40);
    chk(tx_cap, 8'h81);
    tx_run <= 1'b0;
    bus(1'b1, ADDR_MASK, 32'h0000_0008);
    pulse(2, 8'h96, 5);
    pulse(4, 8'h00, 20);
    rx_run <= 1'b1;
    wait_for(1, 1);
    chk({sync_match_flag, read_lost_flag, parallel_read_bus_oe}, 3'b100);
    bus(1'b0, ADDR_FLAGS, 32'h0000_0000);
    chk(got, 32'h0000_0057);
    read_bus(8'h96);
    pulse(3, 8'h00, 5);
    chk(read_request, 1'b0);
    wait_for(1, 1);
    chk({sync_match_flag, read_lost_flag}, 2'b00);
    read_bus(8'h5A);
    // Request left pending so the next byte overwrites it
    wait_for(2, 1);
    chk(irq, 1'b1);
    read_bus(8'hC3);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(got & 32'h0000_001C, 32'h0000_001C);
    pulse(4, 8'h00, 20);
    chk({read_request, read_lost_flag, sync_match_flag}, 3'b000);
    give_verdict();
  end
endmodule

`default_nettype wire

// file: testbench/tape_drive_model.sv
`timescale 1ns/1ns
`default_nettype none

module tape_drive_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        tx_run,
  input  wire logic        rx_run,
  input  wire logic        serial_write_out,
  input  wire logic [39:0] rx_pattern,
  output logic             transmit_clock,
  output logic             receive_clock,
  output logic             serial_read_in,
  output logic [7:0]       tx_cap,
  output int               tx_falls,
  output int               rx_bits
);
  // --------
  // Bit clocks
  // --------
  // Twelve system cycles a bit; clocks stand low outside a run
  int ph;

  always_ff @(posedge clk) begin
    if (srst) begin
      ph <= 0;
      transmit_clock <= 1'b0;
      receive_clock <= 1'b0;
      serial_read_in <= 1'b0;
      tx_cap <= 8'h00;
      tx_falls <= 0;
      rx_bits <= 0;
    end else begin
      ph <= (ph == 11) ? 0 : ph + 1;
      if (ph == 0 && tx_run) begin
        transmit_clock <= 1'b1;
      end
      // Mid-bit capture, LSB first
      if (ph == 6 && transmit_clock) begin
        transmit_clock <= 1'b0;
        tx_cap <= {serial_write_out, tx_cap[7:1]};
        tx_falls <= tx_falls + 1;
      end
      if (ph == 0 && rx_run && rx_bits < 40) begin
        receive_clock <= 1'b1;
        serial_read_in <= rx_pattern[rx_bits];
      end else if (ph == 0) begin
        // Idle line keeps moving so a stale bit cannot pass for data
        serial_read_in <= ~serial_read_in;
      end
      if (ph == 6 && receive_clock) begin
        receive_clock <= 1'b0;
        rx_bits <= rx_bits + 1;
      end
    end
  end
endmodule

`default_nettype wire
